//--- src/tac_ctrl.sv
/*
 * Temperature alert and conversion control: configuration word, alarm state
 * word, bounds, conversion sequencing with averaging and software reset.
 * Assumes a serial bus front end on mclk that issues one-cycle read and write
 * strobes and a stop pulse, and a converter whose output is valid when a
 * conversion time elapses.
 */
`timescale 1ns/100ps
// Operation
// - Set high flag on rising above upper bound or falling below re-arm level.
// - High flag not set again until result below upper bound minus band.
// - Set low flag on falling below lower bound or rising above re-arm level.
// - Low flag not set again until result above lower bound plus band.
// - Reading alarm state word clears high and low flags.
// - New result flag set on each stored result, cleared by alarm read or software reset.
// - Bits 10:9 pick converter time 6.4, 3.5, 2.0 or 1.2 ms.
// - Averaging longer than the period stretches the cycle to the averaging time.
// - Bit 8 starts a 1 ms software reset and always reads zero.
// - Bit 7 averages every measurement over eight conversions.
// - Checksum enable takes effect only after a bus stop.
// - Bit 4 starts one measurement and clears itself when done.
// - A finished single shot leaves the device in shutdown.
// - Bit 3 chooses continuous conversion or shutdown.
// - Bits 2:0 set the conversion period, reset value four.
// - Bounds ignored when upper bound is not above lower bound.
// - Bands are unsigned bytes in half-degree steps.
module tac_ctrl import tac_pkg::*; #(
   parameter int unsigned P_CONV_CYC [0:3] = TAC_CONV_CYC,
   parameter int unsigned P_PERIOD_CYC [0:7] = TAC_PERIOD_CYC,
   parameter int unsigned P_SWRST_CYC = TAC_SWRST_CYC
) (
   input wire logic mclk, // System clock, 50 MHz.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire tac_req_s req, // Register read and write strobes.
   input wire logic bus_stop, // Stop condition seen on the serial bus.
   input wire logic [15:0] adc_data, // Converter output word.
   output logic [15:0] rd_data_r, // Data of the last register read.
   output logic adc_run_r, // Converter is running.
   output logic [1:0] adc_time_sel_r, // Converter time code.
   output logic crc_active_r, // Checksums in force on the bus.
   output logic sw_reset_busy_r // Software reset in progress.
);

   // ----------------------------------------------------------------------
   // Declarations.
   // ----------------------------------------------------------------------
   tac_state_e state_r, state_nxt;
   tac_cfg_s cfg_r, cfg_nxt;
   logic [15:0] lowb_r, upb_r, band_r, result_r;
   logic drdy_r;
   logic [TAC_CNT_W-1:0] tcnt_r, pcnt_r, swcnt_r;
   logic [2:0] sidx_r;
   logic signed [18:0] acc_r;
   logic hi_flag, hi_status, lo_flag, lo_status;

   // ----------------------------------------------------------------------
   // Register decode.
   // ----------------------------------------------------------------------
   // Bus writes are dropped while the software reset runs.
   wire logic busy = (state_r == TAC_ST_SWRST);
   wire logic wr_ok = req.wr && !busy;
   wire logic wr_cfg = wr_ok && (req.addr == TAC_ADDR_CFG);
   wire logic wr_lowb = wr_ok && (req.addr == TAC_ADDR_LOWB);
   wire logic wr_upb = wr_ok && (req.addr == TAC_ADDR_UPB);
   wire logic wr_band = wr_ok && (req.addr == TAC_ADDR_BAND);
   wire logic rd_alarm = req.rd && (req.addr == TAC_ADDR_ALARM);
   wire logic swrst_req = wr_cfg && req.wdata[TAC_CFG_SWRST_BIT];
   wire logic [15:0] alarm_word = {13'h0000, hi_flag, lo_flag, drdy_r};
   wire logic [15:0] cfg_word = cfg_r & TAC_CFG_RWMASK;
   wire logic [15:0] rd_word =
      (req.addr == TAC_ADDR_RESULT) ? result_r :
      (req.addr == TAC_ADDR_ALARM) ? alarm_word :
      (req.addr == TAC_ADDR_CFG) ? cfg_word :
      (req.addr == TAC_ADDR_LOWB) ? lowb_r :
      (req.addr == TAC_ADDR_UPB) ? upb_r :
      (req.addr == TAC_ADDR_BAND) ? band_r : 16'h0000;

   // ----------------------------------------------------------------------
   // Conversion timing and averaging.
   // ----------------------------------------------------------------------
   wire logic [TAC_CNT_W-1:0] conv_lim = TAC_CNT_W'(P_CONV_CYC[cfg_r.conv_time]);
   wire logic [TAC_CNT_W-1:0] per_lim = TAC_CNT_W'(P_PERIOD_CYC[cfg_r.period]);
   // A shorter converter time chosen mid-way ends the conversion at once instead of wrapping the counter.
   wire logic conv_end = (state_r == TAC_ST_CONV) && (tcnt_r >= conv_lim - 1'b1);
   wire logic last_samp = !cfg_r.eightfold_mean_en || (sidx_r == TAC_AVG_LAST);
   wire logic store = conv_end && last_samp;
   wire logic signed [18:0] sum_nxt = acc_r + 19'(signed'(adc_data));
   wire logic [15:0] mean_val = cfg_r.eightfold_mean_en ?
      sum_nxt[TAC_AVG_SHIFT +: 16] : adc_data;
   wire logic period_done = (pcnt_r >= per_lim - 1'b1);
   wire logic cycle_start = (state_nxt == TAC_ST_CONV) && (state_r != TAC_ST_CONV);

   // ----------------------------------------------------------------------
   // Alarm inputs on the result scale.
   // ----------------------------------------------------------------------
   wire logic bounds_ok = $signed(upb_r[15:2]) > $signed(lowb_r[15:2]);
   wire logic [15:0] result_nxt_s = mean_val;
   wire logic signed [17:0] res_ext = {{2{result_nxt_s[15]}}, result_nxt_s};
   wire logic signed [17:0] upb_ext = {{2{upb_r[15]}}, upb_r & TAC_BOUND_MASK};
   wire logic signed [17:0] lowb_ext = {{2{lowb_r[15]}}, lowb_r & TAC_BOUND_MASK};
   wire logic signed [17:0] hband = 18'({band_r[15:8], 6'h00});
   wire logic signed [17:0] lband = 18'({band_r[7:0], 6'h00});

   // ----------------------------------------------------------------------
   // Sequencer next state.
   // ----------------------------------------------------------------------
   // Continuous mode restarts each period; shutdown or single shot parks idle.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         TAC_ST_IDLE: begin
            if (cfg_r.single_shot_trigger || !cfg_r.shutdown) begin
               state_nxt = TAC_ST_CONV;
            end
         end
         TAC_ST_CONV: begin
            if (store) begin
               state_nxt = (cfg_r.shutdown || cfg_r.single_shot_trigger) ?
                  TAC_ST_IDLE : TAC_ST_WAIT;
            end
         end
         TAC_ST_WAIT: begin
            if (cfg_r.single_shot_trigger) begin
               state_nxt = TAC_ST_CONV;
            end else if (cfg_r.shutdown) begin
               state_nxt = TAC_ST_IDLE;
            end else if (period_done) begin
               state_nxt = TAC_ST_CONV;
            end
         end
         TAC_ST_SWRST: begin
            if (swcnt_r == TAC_CNT_W'(P_SWRST_CYC - 1)) begin
               state_nxt = TAC_ST_IDLE;
            end
         end
         default: state_nxt = TAC_ST_IDLE;
      endcase
      if (swrst_req) begin
         state_nxt = TAC_ST_SWRST;
      end
   end

   // Configuration word next value; reset bit and reserved bits never stored.
   always_comb begin
      cfg_nxt = cfg_r;
      if (wr_cfg) begin
         cfg_nxt = tac_cfg_s'(req.wdata & TAC_CFG_RWMASK);
      end
      if (store && cfg_r.single_shot_trigger) begin
         cfg_nxt.single_shot_trigger = 1'b0;
         cfg_nxt.shutdown = 1'b1;
      end
      if (swrst_req) begin
         cfg_nxt = tac_cfg_s'(TAC_CFG_RST);
      end
   end

   // ----------------------------------------------------------------------
   // State and counters.
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r <= TAC_ST_IDLE;
         cfg_r <= tac_cfg_s'(TAC_CFG_RST);
         swcnt_r <= '0;
         tcnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         cfg_r <= cfg_nxt;
         swcnt_r <= busy ? swcnt_r + 1'b1 : '0;
         tcnt_r <= (state_r == TAC_ST_CONV && !conv_end) ? tcnt_r + 1'b1 : '0;
      end
   end

   // Period counter starts with each cycle and saturates; a long averaged
   // measurement simply finds the period already spent.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pcnt_r <= '0;
      end else begin
         pcnt_r <= cycle_start ? '0 : ((&pcnt_r) ? pcnt_r : pcnt_r + 1'b1);
      end
   end

   // Sample index and accumulator for the eight-conversion mean.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sidx_r <= '0;
         acc_r <= '0;
      end else begin
         sidx_r <= (state_r != TAC_ST_CONV || store) ? '0 : (conv_end ? sidx_r + 1'b1 : sidx_r);
         acc_r <= (state_r != TAC_ST_CONV || store) ? '0 : (conv_end ? sum_nxt : acc_r);
      end
   end

   // ----------------------------------------------------------------------
   // Bounds, result and new result flag.
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lowb_r <= TAC_LOWB_RST;
         upb_r <= TAC_UPB_RST;
         band_r <= TAC_BAND_RST;
      end else begin
         lowb_r <= swrst_req ? TAC_LOWB_RST : (wr_lowb ? req.wdata & TAC_BOUND_MASK : lowb_r);
         upb_r <= swrst_req ? TAC_UPB_RST : (wr_upb ? req.wdata & TAC_BOUND_MASK : upb_r);
         band_r <= swrst_req ? TAC_BAND_RST : (wr_band ? req.wdata : band_r);
      end
   end

   // New result flag: a store in the reading cycle wins over the clear.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         result_r <= TAC_RESULT_RST;
         drdy_r <= 1'b0;
      end else begin
         result_r <= swrst_req ? TAC_RESULT_RST : (store ? mean_val : result_r);
         drdy_r <= swrst_req ? 1'b0 : (store ? 1'b1 : (rd_alarm ? 1'b0 : drdy_r));
      end
   end

   // ----------------------------------------------------------------------
   // Crossing flags.
   // ----------------------------------------------------------------------
   tac_hyst_flag #(.UPPER(1'b1)) u_high (
      .mclk(mclk),
      .rstn(rstn),
      .clr_all(swrst_req),
      .sample(store),
      .enable(bounds_ok),
      .value(res_ext),
      .bound(upb_ext),
      .band(hband),
      .rd_clear(rd_alarm),
      .flag_r(hi_flag),
      .status_r(hi_status)
   );

   tac_hyst_flag #(.UPPER(1'b0)) u_low (
      .mclk(mclk),
      .rstn(rstn),
      .clr_all(swrst_req),
      .sample(store),
      .enable(bounds_ok),
      .value(res_ext),
      .bound(lowb_ext),
      .band(lband),
      .rd_clear(rd_alarm),
      .flag_r(lo_flag),
      .status_r(lo_status)
   );

   // ----------------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------------
   // Checksum enable is copied into force only on a stop.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rd_data_r <= 16'h0000;
         crc_active_r <= 1'b0;
         adc_run_r <= 1'b0;
         adc_time_sel_r <= 2'h0;
         sw_reset_busy_r <= 1'b0;
      end else begin
         rd_data_r <= req.rd ? rd_word : rd_data_r;
         crc_active_r <= swrst_req ? 1'b0 : (bus_stop ? cfg_r.crc_en : crc_active_r);
         adc_run_r <= (state_nxt == TAC_ST_CONV);
         adc_time_sel_r <= cfg_nxt.conv_time;
         sw_reset_busy_r <= (state_nxt == TAC_ST_SWRST);
      end
   end

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------
   default clocking dcb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence s_swrst_end;
      (state_r == TAC_ST_SWRST) ##1 (state_r != TAC_ST_SWRST);
   endsequence
   sequence s_shot_done;
      store && cfg_r.single_shot_trigger && !swrst_req && !wr_cfg;
   endsequence

   AST_RSVD_ZERO: assert property (req.rd && req.addr == TAC_ADDR_CFG |=>
      (rd_data_r[15:11] == 5'h00) && !rd_data_r[5])
      else $error("reserved configuration bits read nonzero");
   AST_SWRST_READ0: assert property (req.rd && req.addr == TAC_ADDR_CFG |=>
      !rd_data_r[TAC_CFG_SWRST_BIT])
      else $error("software reset bit read as one");
   AST_SWRST_LEN: assert property (s_swrst_end |->
      $past(swcnt_r) == TAC_CNT_W'(P_SWRST_CYC - 1))
      else $error("software reset length wrong");
   AST_SWRST_CFG: assert property (swrst_req |=>
      (cfg_r.period == 3'h4) && sw_reset_busy_r)
      else $error("configuration not back at reset value");
   AST_RD_CLEARS: assert property (rd_alarm && !store && !swrst_req |=>
      !hi_flag && !lo_flag && !drdy_r)
      else $error("alarm read did not clear flags");
   AST_NEW_RESULT: assert property (store && !swrst_req |=>
      drdy_r && result_r == $past(mean_val))
      else $error("new result flag not set");
   AST_SHOT_DONE: assert property (s_shot_done |=>
      !cfg_r.single_shot_trigger ##0 cfg_r.shutdown ##0 state_r == TAC_ST_IDLE)
      else $error("single shot did not end in shutdown");
   AST_SHUTDOWN: assert property (state_r == TAC_ST_IDLE && cfg_r.shutdown &&
      !cfg_r.single_shot_trigger && !swrst_req |=> !adc_run_r)
      else $error("conversion started in shutdown");
   AST_CRC_HOLD: assert property (!bus_stop && !swrst_req |=> $stable(crc_active_r))
      else $error("checksum enable changed without stop");
   AST_AVG_EIGHT: assert property (store |->
      (cfg_r.eightfold_mean_en ? sidx_r == TAC_AVG_LAST : sidx_r == 3'h0))
      else $error("wrong number of conversions averaged");
   AST_CONV_LEN: assert property ((state_r == TAC_ST_CONV) &&
      $stable(cfg_r.conv_time) |-> tcnt_r < conv_lim)
      else $error("conversion ran past its time");
   AST_STRETCH: assert property ((state_r == TAC_ST_WAIT) |-> !period_done ||
      cfg_r.shutdown || cfg_r.single_shot_trigger || state_nxt != TAC_ST_WAIT)
      else $error("waited past an elapsed period");
   AST_STATUS_HOLD: assert property (!store && !swrst_req |=>
      $stable(hi_status) && $stable(lo_status))
      else $error("crossing state changed without a stored result");

endmodule // tac_ctrl

//--- src/tac_pkg.sv
/*
 * Package for the temperature alert and conversion control block: register
 * offsets, reset values, field positions, timing figures and shared types.
 * Assumes a 50 MHz mclk and a 16-bit register word behind an 8-bit pointer.
 */
package tac_pkg;

   // ----------------------------------------------------------------------
   // Clock and timing figures.
   // ----------------------------------------------------------------------
   localparam real TAC_MCLK_NS = 20.0;
   localparam int TAC_CNT_W = 27;
   localparam real TAC_CONV_MS [0:3] = '{6.4, 3.5, 2.0, 1.2};
   localparam real TAC_PERIOD_MS [0:7] = '{6.4, 31.25, 62.5, 125.0, 250.0, 500.0, 1000.0,
                                           2000.0};
   localparam real TAC_SWRST_MS = 1.0;

   // Converts a least time in milliseconds to whole mclk cycles, rounded up.
   function automatic int unsigned tac_ms2cyc(real ms);
      return int'($ceil(ms * 1.0e6 / TAC_MCLK_NS));
   endfunction

   localparam int unsigned TAC_CONV_CYC [0:3] = '{tac_ms2cyc(TAC_CONV_MS[0]),
      tac_ms2cyc(TAC_CONV_MS[1]), tac_ms2cyc(TAC_CONV_MS[2]), tac_ms2cyc(TAC_CONV_MS[3])};
   localparam int unsigned TAC_PERIOD_CYC [0:7] = '{tac_ms2cyc(TAC_PERIOD_MS[0]),
      tac_ms2cyc(TAC_PERIOD_MS[1]), tac_ms2cyc(TAC_PERIOD_MS[2]),
      tac_ms2cyc(TAC_PERIOD_MS[3]), tac_ms2cyc(TAC_PERIOD_MS[4]),
      tac_ms2cyc(TAC_PERIOD_MS[5]), tac_ms2cyc(TAC_PERIOD_MS[6]),
      tac_ms2cyc(TAC_PERIOD_MS[7])};
   localparam int unsigned TAC_SWRST_CYC = tac_ms2cyc(TAC_SWRST_MS);

   // ----------------------------------------------------------------------
   // Register offsets and reset values.
   // ----------------------------------------------------------------------
   localparam logic [7:0] TAC_ADDR_RESULT = 8'h00;
   localparam logic [7:0] TAC_ADDR_ALARM = 8'h02;
   localparam logic [7:0] TAC_ADDR_CFG = 8'h03;
   localparam logic [7:0] TAC_ADDR_LOWB = 8'h04;
   localparam logic [7:0] TAC_ADDR_UPB = 8'h05;
   localparam logic [7:0] TAC_ADDR_BAND = 8'h06;
   localparam logic [15:0] TAC_CFG_RST = 16'h0004;
   localparam logic [15:0] TAC_LOWB_RST = 16'hf380;
   localparam logic [15:0] TAC_UPB_RST = 16'h2a80;
   localparam logic [15:0] TAC_BAND_RST = 16'h0a0a;
   localparam logic [15:0] TAC_RESULT_RST = 16'h0000;

   // ----------------------------------------------------------------------
   // Field positions and masks.
   // ----------------------------------------------------------------------
   localparam logic [15:0] TAC_CFG_RWMASK = 16'h06df;
   localparam logic [15:0] TAC_BOUND_MASK = 16'hfffc;
   localparam int TAC_CFG_SWRST_BIT = 8;
   localparam int TAC_ST_HIGH_BIT = 2;
   localparam int TAC_ST_LOW_BIT = 1;
   localparam int TAC_ST_NEW_BIT = 0;
   localparam int TAC_BAND_SHIFT = 6;
   localparam logic [2:0] TAC_AVG_LAST = 3'h7;
   localparam int TAC_AVG_SHIFT = 3;

   // ----------------------------------------------------------------------
   // Shared types.
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [4:0] rsvd_hi;
      logic [1:0] conv_time;
      logic sw_reset;
      logic eightfold_mean_en;
      logic crc_en;
      logic rsvd5;
      logic single_shot_trigger;
      logic shutdown;
      logic [2:0] period;
   } tac_cfg_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } tac_req_s;

   typedef enum logic [1:0] {
      TAC_ST_IDLE = 2'b00,
      TAC_ST_CONV = 2'b01,
      TAC_ST_WAIT = 2'b10,
      TAC_ST_SWRST = 2'b11
   } tac_state_e;

endpackage

//--- src/tac_hyst_flag.sv
/*
 * One threshold crossing flag with hysteresis re-arm, used once for the
 * upper bound and once for the lower bound.
 * Assumes value, bound and band share one scale and arrive on mclk.
 */
`timescale 1ns/100ps
module tac_hyst_flag import tac_pkg::*; #(
   parameter bit UPPER = 1'b1
) (
   input wire logic mclk, // System clock.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire logic clr_all, // Software reset pulse.
   input wire logic sample, // A result is being stored.
   input wire logic enable, // Bounds are valid.
   input wire logic signed [17:0] value, // Stored result, sign extended.
   input wire logic signed [17:0] bound, // Bound on the result scale.
   input wire logic signed [17:0] band, // Hysteresis band on the result scale.
   input wire logic rd_clear, // Alarm state word is being read.
   output logic flag_r, // Sticky crossing flag.
   output logic status_r // Tripped; set past the bound, cleared past the re-arm level.
);

   // ----------------------------------------------------------------------
   // Crossing detection.
   // ----------------------------------------------------------------------
   // The band is unsigned and already scaled from half-degree steps.
   wire logic signed [17:0] rearm_thr = UPPER ? (bound - band) : (bound + band);
   wire logic trip = UPPER ? (value > bound) : (value < bound);
   wire logic release_ev = UPPER ? (value < rearm_thr) : (value > rearm_thr);
   // Once tripped, only the re-arm crossing can raise the flag again.
   wire logic set_ev = sample && enable && (status_r ? release_ev : trip);

   // Side state and flag; a set in the clearing cycle wins.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         status_r <= 1'b0;
         flag_r <= 1'b0;
      end else begin
         status_r <= clr_all ? 1'b0 : (set_ev ? !status_r : status_r);
         flag_r <= clr_all ? 1'b0 : (set_ev ? 1'b1 : (rd_clear ? 1'b0 : flag_r));
      end
   end

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------
   AST_TRIP_SETS: assert property (@(posedge mclk) disable iff (!rstn)
      (sample && enable && !status_r && trip && !clr_all) |=> (flag_r && status_r))
      else $error("crossing did not raise the flag");
   AST_NO_REARM: assert property (@(posedge mclk) disable iff (!rstn)
      (status_r && !(sample && enable && release_ev) && !clr_all && rd_clear) |=> !flag_r)
      else $error("flag raised again before re-arm");
   AST_IGNORE_BOUNDS: assert property (@(posedge mclk) disable iff (!rstn)
      (!enable && !clr_all) |=> $stable(status_r))
      else $error("bounds used while invalid");

endmodule // tac_hyst_flag

//--- tb/tac_host.sv
/*
 * Host model: issues register writes and reads as one-cycle strobes.
 * Assumes the block answers a read on the edge after the strobe.
 */
`timescale 1ns/100ps
module tac_host import tac_pkg::*; (
   input wire logic mclk, // System clock.
   input wire logic [15:0] rd_data_r, // Read data from the block.
   output tac_req_s req // Strobes toward the block.
);
   initial req = '0;
   // One write; when released, address and data show their inverse so stale values never pass.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
      @(posedge mclk) req <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   // One read; the word is taken once the answering edge has settled.
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk) req <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge mclk) req <= '{1'b0, 1'b0, ~a, 16'hffff};
      #1 d = rd_data_r;
   endtask
endmodule // tac_host

//--- tb/tb_tac_ctrl.sv
/*
 * Testbench for tac_ctrl: register table, conversion timing, flags, stop, soft reset.
 * Assumes shortened counts given below and the host model in tac_host.
 */
`timescale 1ns/100ps
module tb_tac_ctrl import tac_pkg::*;;
   localparam int unsigned CONV [0:3] = '{40, 30, 20, 10};
   logic mclk = 1'b0, rstn = 1'b0, bus_stop = 1'b0;
   logic [15:0] adc_data = 16'h0000, rd_data_r, d;
   logic [1:0] adc_time_sel_r;
   logic adc_run_r, crc_active_r, sw_reset_busy_r;
   tac_req_s req;
   int n_errors = 0, tests_run = 0, n, i;
   logic [39:0] rows [0:3] = '{{8'h03, 16'hfeef, 16'h06cf}, {8'h03, 16'h0008, 16'h0008},
      {8'h0a, 16'h1234, 16'h0000}, {8'h05, 16'h2a83, 16'h2a80}};
   logic [31:0] fl [0:5] = '{32'h3000_0005, 32'h3000_0001, 32'h2000_0005,
      32'he000_0003, 32'he000_0001, 32'h0000_0003};
   // Clock at 50 MHz.
   always #10 mclk = ~mclk;
   tac_ctrl #(.P_CONV_CYC(CONV), .P_PERIOD_CYC('{50, 60, 70, 80, 90, 100, 110, 120}),
      .P_SWRST_CYC(20)) tac_ctrl_i (.mclk(mclk), .rstn(rstn), .req(req), .bus_stop(bus_stop),
      .adc_data(adc_data), .rd_data_r(rd_data_r), .adc_run_r(adc_run_r),
      .adc_time_sel_r(adc_time_sel_r), .crc_active_r(crc_active_r),
      .sw_reset_busy_r(sw_reset_busy_r));
   tac_host tac_host_i (.mclk(mclk), .rd_data_r(rd_data_r), .req(req));
   // ----------------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Counts the high cycles of the run or busy level, each wait bounded.
   task automatic count(input bit sw, output int c);
      int k;
      c = 0;
      for (k = 0; k < 400 && (sw ? sw_reset_busy_r : adc_run_r) !== 1'b1; k++) @(negedge mclk);
      while ((sw ? sw_reset_busy_r : adc_run_r) === 1'b1 && c < 2000) begin
         @(negedge mclk);
         c++;
      end
   endtask
   // Counts the low cycles between two conversions, bounded.
   task automatic gap(output int c);
      for (c = 0; c < 400 && adc_run_r !== 1'b1; c++) @(negedge mclk);
   endtask
   // Starts one single shot with a given converter word.
   task automatic shot(input logic [15:0] cfg, input logic [15:0] val);
      @(posedge mclk) adc_data <= val;
      tac_host_i.wr(8'h03, cfg);
      count(1'b0, n);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Watchdog, far beyond the roughly 1300 cycles the tests need.
   initial begin
      #400000;
      n_errors++;
      print_verdict();
   end
   // Main sequence.
   initial begin
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      tac_host_i.rd(8'h03, d);
      chk(d, 16'h0004, "cfg reset");
      for (i = 0; i < 4; i++) begin
         tac_host_i.wr(rows[i][39:32], rows[i][31:16]);
         tac_host_i.rd(rows[i][39:32], d);
         chk(d, rows[i][15:0], "reg row");
      end
      $display("test regs done");
      for (i = 0; i < 500 && adc_run_r !== 1'b0; i++) @(negedge mclk);
      tac_host_i.rd(8'h02, d);
      for (i = 0; i < 4; i++) begin
         shot({5'h00, i[1:0], 9'h018}, 16'h0100);
         chk(16'(n), 16'(CONV[i]), "conv time");
         chk({14'h0000, adc_time_sel_r}, 16'(i), "time code");
      end
      tac_host_i.rd(8'h03, d);
      chk(d, 16'h0608, "shot cleared");
      chk({15'h0000, adc_run_r}, 16'h0000, "stays idle");
      tac_host_i.rd(8'h02, d);
      chk(d, 16'h0001, "new only");
      $display("test timing done");
      for (i = 0; i < 6; i++) begin
         shot(16'h0018, fl[i][31:16]);
         tac_host_i.rd(8'h02, d);
         chk(d, fl[i][15:0], "alarm");
      end
      shot(16'h0098, 16'h0100);
      chk(16'(n), 16'd320, "avg run");
      tac_host_i.rd(8'h02, d);
      chk(d, 16'h0001, "avg result");
      tac_host_i.rd(8'h02, d);
      chk(d, 16'h0000, "read clears");
      tac_host_i.wr(8'h04, 16'h2a80);
      shot(16'h0018, 16'h3000);
      tac_host_i.rd(8'h02, d);
      chk(d, 16'h0001, "bounds ignored");
      $display("test flags done");
      tac_host_i.wr(8'h03, 16'h0087);
      count(1'b0, n);
      chk(16'(n), 16'd320, "avg continuous run");
      gap(n);
      chk(16'(n), 16'd1, "stretched gap");
      tac_host_i.wr(8'h03, 16'h0007);
      count(1'b0, n);
      gap(n);
      chk(16'(n), 16'd80, "period gap");
      $display("test period done");
      tac_host_i.wr(8'h03, 16'h0048);
      @(negedge mclk);
      chk({15'h0000, crc_active_r}, 16'h0000, "crc early");
      @(posedge mclk) bus_stop <= 1'b1;
      @(posedge mclk) bus_stop <= 1'b0;
      @(negedge mclk);
      chk({15'h0000, crc_active_r}, 16'h0001, "crc after stop");
      tac_host_i.wr(8'h03, 16'h0108);
      count(1'b1, n);
      chk(16'(n), 16'd20, "soft reset span");
      tac_host_i.rd(8'h03, d);
      chk(d, 16'h0004, "cfg after soft reset");
      tac_host_i.rd(8'h04, d);
      chk(d, 16'hf380, "lower bound after soft reset");
      $display("test stop and soft reset done");
      print_verdict();
   end
endmodule // tb_tac_ctrl
